// ===== design/dpgio_top.sv
// Dual-port GPIO block with first-port interrupts, APB register slave
`timescale 1ns/1ps
`include "dpgio_defs.svh"

module dpgio_top #(
  parameter int A_W = `DPGIO_A_W,
  parameter int B_W = `DPGIO_B_W,
  parameter int DEB_LEN = `DPGIO_DEB_LEN
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire dpgio_pkg::dpgio_apb_req_t apb_req,
  output dpgio_pkg::dpgio_apb_rsp_t apb_rsp,
  // First-port pads
  input wire logic [A_W-1:0] pad_a_in,
  output dpgio_pkg::dpgio_drv_a_t pad_a_drv,
  // Second-port pads
  input wire logic [B_W-1:0] second_port_lines_in,
  output dpgio_pkg::dpgio_drv_b_t second_port_lines_drv,
  // Hardware function drive
  input wire dpgio_pkg::dpgio_drv_a_t hw_a,
  input wire dpgio_pkg::dpgio_drv_b_t hw_b,
  // Synchronised line levels for wake-up and hardware functions
  output logic [A_W-1:0] line_a_lvl,
  output logic [B_W-1:0] line_b_lvl,
  // Interrupt
  output logic irq
);
  import dpgio_pkg::*;

  // -------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------
  // Bus structs are fixed at the documented port widths
  if (A_W != `DPGIO_A_W || B_W != `DPGIO_B_W) begin : g_bad_width
    $error("dpgio_top: port widths must match the bundle widths");
  end
  if (DEB_LEN < 2) begin : g_bad_deb
    $error("dpgio_top: debounce length must be at least 2");
  end

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [A_W-1:0] dr_a;
    logic [A_W-1:0] ddr_a;
    logic ctl_a;
    logic [B_W-1:0] dr_b;
    logic [B_W-1:0] ddr_b;
    logic ctl_b;
    logic [A_W-1:0] inten;
    logic [A_W-1:0] mask;
    logic [A_W-1:0] itype;
    logic [A_W-1:0] ipol;
    logic [A_W-1:0] deb;
    logic [A_W-1:0] raw;
    logic [A_W-1:0] sa1;
    logic [A_W-1:0] sa2;
    logic [B_W-1:0] sb1;
    logic [B_W-1:0] sb2;
    logic [DEB_LEN-1:0][A_W-1:0] hist;
    logic [A_W-1:0] filt;
    logic [A_W-1:0] filt_d;
    logic [A_W-1:0] a_out;
    logic [A_W-1:0] a_oe;
    logic [B_W-1:0] b_out;
    logic [B_W-1:0] b_oe;
    logic [A_W-1:0] lvl_a;
    logic [B_W-1:0] lvl_b;
    logic irq;
    logic pready;
    logic pslverr;
    logic [`DPGIO_DATA_W-1:0] prdata;
  } dpgio_st_t;

  dpgio_st_t st_ff;
  dpgio_st_t nxt_st;

  logic setup;
  logic acc_wr;
  logic map_ok;
  logic [`DPGIO_DATA_W-1:0] rd_val;
  logic [A_W-1:0] clr_raw;
  logic [A_W-1:0] all_one;
  logic [A_W-1:0] all_zero;
  logic [A_W-1:0] lvl_act;
  logic [A_W-1:0] edge_ev;

  // -------------------------------------------------------------------
  // Read multiplexer
  // -------------------------------------------------------------------
  // Unused upper bits stay zero from the default below
  always_comb begin
    rd_val = '0;
    map_ok = 1'b1;
    case (apb_req.paddr)
      `DPGIO_OFF_A_DR: rd_val[A_W-1:0] = st_ff.dr_a;
      `DPGIO_OFF_A_DDR: rd_val[A_W-1:0] = st_ff.ddr_a;
      `DPGIO_OFF_A_SRC: rd_val[`DPGIO_SRC_BIT] = st_ff.ctl_a;
      `DPGIO_OFF_B_DR: rd_val[B_W-1:0] = st_ff.dr_b;
      `DPGIO_OFF_B_DDR: rd_val[B_W-1:0] = st_ff.ddr_b;
      `DPGIO_OFF_B_SRC: rd_val[`DPGIO_SRC_BIT] = st_ff.ctl_b;
      `DPGIO_OFF_IEN: rd_val[A_W-1:0] = st_ff.inten;
      `DPGIO_OFF_IMSK: rd_val[A_W-1:0] = st_ff.mask;
      `DPGIO_OFF_ITYP: rd_val[A_W-1:0] = st_ff.itype;
      `DPGIO_OFF_IPOL: rd_val[A_W-1:0] = st_ff.ipol;
      `DPGIO_OFF_ISTAT: rd_val[A_W-1:0] = st_ff.raw & st_ff.inten & ~st_ff.mask;
      `DPGIO_OFF_IRAW: rd_val[A_W-1:0] = st_ff.raw;
      `DPGIO_OFF_IDEB: rd_val[A_W-1:0] = st_ff.deb;
      `DPGIO_OFF_A_PIN: rd_val[A_W-1:0] = st_ff.lvl_a;
      `DPGIO_OFF_B_PIN: rd_val[B_W-1:0] = st_ff.lvl_b;
      default: map_ok = 1'b0;
    endcase
  end

  // -------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    setup = apb_req.psel & ~apb_req.penable;
    // Writes land only at the access edge that sees pready
    acc_wr = apb_req.psel & apb_req.penable & apb_req.pwrite & st_ff.pready;
    clr_raw = '0;

    // Pad synchronisers, first stage read only by the second
    nxt_st.sa1 = pad_a_in;
    nxt_st.sa2 = st_ff.sa1;
    nxt_st.sb1 = second_port_lines_in;
    nxt_st.sb2 = st_ff.sb1;
    nxt_st.lvl_a = st_ff.sa2;
    nxt_st.lvl_b = st_ff.sb2;

    // Register writes; a refused address changes nothing
    if (acc_wr) begin
      case (apb_req.paddr)
        `DPGIO_OFF_A_DR: nxt_st.dr_a = apb_req.pwdata[A_W-1:0];
        `DPGIO_OFF_A_DDR: nxt_st.ddr_a = apb_req.pwdata[A_W-1:0];
        `DPGIO_OFF_A_SRC: nxt_st.ctl_a = apb_req.pwdata[`DPGIO_SRC_BIT];
        `DPGIO_OFF_B_DR: nxt_st.dr_b = apb_req.pwdata[B_W-1:0];
        `DPGIO_OFF_B_DDR: nxt_st.ddr_b = apb_req.pwdata[B_W-1:0];
        `DPGIO_OFF_B_SRC: nxt_st.ctl_b = apb_req.pwdata[`DPGIO_SRC_BIT];
        `DPGIO_OFF_IEN: nxt_st.inten = apb_req.pwdata[A_W-1:0];
        `DPGIO_OFF_IMSK: nxt_st.mask = apb_req.pwdata[A_W-1:0];
        `DPGIO_OFF_ITYP: nxt_st.itype = apb_req.pwdata[A_W-1:0];
        `DPGIO_OFF_IPOL: nxt_st.ipol = apb_req.pwdata[A_W-1:0];
        `DPGIO_OFF_IRAW: clr_raw = apb_req.pwdata[A_W-1:0];
        `DPGIO_OFF_IDEB: nxt_st.deb = apb_req.pwdata[A_W-1:0];
        default: ;
      endcase
    end

    // Debounce: a line with its deb bit set moves only after DEB_LEN equal samples; a clear bit passes sa2 through.
    // Only the first port has a filter; the second has no such path.
    nxt_st.hist = {st_ff.hist[DEB_LEN-2:0], st_ff.sa2};
    for (int i = 0; i < A_W; i++) begin
      all_one[i] = 1'b1;
      all_zero[i] = 1'b1;
      for (int j = 0; j < DEB_LEN; j++) begin
        all_one[i] = all_one[i] & st_ff.hist[j][i];
        all_zero[i] = all_zero[i] & ~st_ff.hist[j][i];
      end
      if (!st_ff.deb[i]) begin
        nxt_st.filt[i] = st_ff.sa2[i];
      end else if (all_one[i]) begin
        nxt_st.filt[i] = 1'b1;
      end else if (all_zero[i]) begin
        nxt_st.filt[i] = 1'b0;
      end
    end
    nxt_st.filt_d = st_ff.filt;

    // Detection on the filtered level
    lvl_act = ~(st_ff.ipol ^ st_ff.filt);
    edge_ev = (st_ff.ipol & st_ff.filt & ~st_ff.filt_d)
            | (~st_ff.ipol & ~st_ff.filt & st_ff.filt_d);
    // Level lines follow the pin; edge lines are sticky, and a new edge
    // beats a write-one clear in the same cycle
    nxt_st.raw = nxt_st.inten & ((~st_ff.itype & lvl_act)
               | (st_ff.itype & (edge_ev | (st_ff.raw & ~clr_raw))));
    nxt_st.irq = |(nxt_st.raw & nxt_st.inten & ~nxt_st.mask);

    // Line drive: registers or hardware functions per port
    nxt_st.a_out = st_ff.ctl_a ? hw_a.dout : st_ff.dr_a;
    nxt_st.a_oe = st_ff.ctl_a ? hw_a.oe : st_ff.ddr_a;
    nxt_st.b_out = st_ff.ctl_b ? hw_b.dout : st_ff.dr_b;
    nxt_st.b_oe = st_ff.ctl_b ? hw_b.oe : st_ff.ddr_b;

    // Zero-wait APB answer, registered off the setup cycle
    nxt_st.pready = setup;
    nxt_st.pslverr = setup & ~map_ok;
    nxt_st.prdata = (setup & ~apb_req.pwrite) ? rd_val : '0;
  end

  // -------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------
  // Everything resets to zero: outputs low, lines inputs, software mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= `DPGIO_RST_ZERO;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // -------------------------------------------------------------------
  // Outputs, straight from flops
  // -------------------------------------------------------------------
  // Port A on pads 00..17, port B on pads 18..34 by index order
  assign pad_a_drv.dout = st_ff.a_out;
  assign pad_a_drv.oe = st_ff.a_oe;
  assign second_port_lines_drv.dout = st_ff.b_out;
  assign second_port_lines_drv.oe = st_ff.b_oe;
  assign line_a_lvl = st_ff.lvl_a;
  assign line_b_lvl = st_ff.lvl_b;
  assign irq = st_ff.irq;
  assign apb_rsp.pready = st_ff.pready;
  assign apb_rsp.pslverr = st_ff.pslverr;
  assign apb_rsp.prdata = st_ff.prdata;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  // Software mode copies the data and direction registers a cycle later
  property p_sw_drive;
    @(posedge core_clk) disable iff (!rst_n)
      !st_ff.ctl_a |=> (pad_a_drv.dout == $past(st_ff.dr_a))
                    && (pad_a_drv.oe == $past(st_ff.ddr_a));
  endproperty
  a_sw_drive: assert property (p_sw_drive)
    else $error("port A software drive mismatch");

  // Hardware mode follows the function signals
  property p_hw_drive;
    @(posedge core_clk) disable iff (!rst_n)
      st_ff.ctl_b |=> (second_port_lines_drv.dout == $past(hw_b.dout))
                   && (second_port_lines_drv.oe == $past(hw_b.oe));
  endproperty
  a_hw_drive: assert property (p_hw_drive)
    else $error("port B hardware drive mismatch");

  // Interrupt output is the OR of the masked status
  property p_irq_or;
    @(posedge core_clk) disable iff (!rst_n)
      irq == |(st_ff.raw & st_ff.inten & ~st_ff.mask);
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("interrupt output disagrees with masked status");

  // Fully masked lines never raise the output
  property p_mask_blocks;
    @(posedge core_clk) disable iff (!rst_n)
      (st_ff.mask == {A_W{1'b1}}) |-> !irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("interrupt raised while all lines masked");

  // A disabled line never shows raw status
  property p_en_gate;
    @(posedge core_clk) disable iff (!rst_n)
      (st_ff.raw & ~st_ff.inten) == '0;
  endproperty
  a_en_gate: assert property (p_en_gate)
    else $error("raw status set on a disabled line");

  // Level lines track the active level of the previous filtered sample
  property p_level;
    @(posedge core_clk) disable iff (!rst_n)
      $stable(st_ff.inten) && $stable(st_ff.itype) && $stable(st_ff.ipol)
        |-> ((st_ff.inten & ~st_ff.itype
             & (st_ff.raw ^ ~($past(st_ff.ipol) ^ $past(st_ff.filt)))) == '0);
  endproperty
  a_level: assert property (p_level)
    else $error("level interrupt status wrong");

  // An enabled rising edge on a rising-edge line is caught next cycle
  property p_edge;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (($past(st_ff.itype) & $past(st_ff.ipol) & $past(st_ff.filt)
                 & ~$past(st_ff.filt_d) & st_ff.inten & ~st_ff.raw) == '0);
  endproperty
  a_edge: assert property (p_edge)
    else $error("rising edge not latched");

  // Without debounce the filter passes the synchronised level through
  property p_no_deb;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> ((~$past(st_ff.deb) & (st_ff.filt ^ $past(st_ff.sa2))) == '0);
  endproperty
  a_no_deb: assert property (p_no_deb)
    else $error("undebounced line not passed through");

  // With debounce a filtered line moves only after a stable history
  property p_deb_hold;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (($past(st_ff.deb) & (st_ff.filt ^ $past(st_ff.filt))
                 & ~$past(all_one) & ~$past(all_zero)) == '0);
  endproperty
  a_deb_hold: assert property (p_deb_hold)
    else $error("debounced line moved on unstable input");

  // Reserved bits of a port A read are zero
  property p_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
      (setup && !apb_req.pwrite && apb_req.paddr == `DPGIO_OFF_A_DR)
        |=> apb_rsp.pready && (apb_rsp.prdata[`DPGIO_DATA_W-1:A_W] == '0);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved read bits not zero");

  // Port B software mode copies its registers a cycle later
  property p_sw_drive_b;
    @(posedge core_clk) disable iff (!rst_n)
      !st_ff.ctl_b |=> (second_port_lines_drv.dout == $past(st_ff.dr_b))
                    && (second_port_lines_drv.oe == $past(st_ff.ddr_b));
  endproperty
  a_sw_drive_b: assert property (p_sw_drive_b)
    else $error("port B software drive mismatch");

  // Port A hardware mode follows the function signals
  property p_hw_drive_a;
    @(posedge core_clk) disable iff (!rst_n)
      st_ff.ctl_a |=> (pad_a_drv.dout == $past(hw_a.dout))
                   && (pad_a_drv.oe == $past(hw_a.oe));
  endproperty
  a_hw_drive_a: assert property (p_hw_drive_a)
    else $error("port A hardware drive mismatch");

  // Zero wait states: ready exactly in the cycle after setup
  property p_ready;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (apb_rsp.pready == $past(setup));
  endproperty
  a_ready: assert property (p_ready)
    else $error("bus ready not one cycle after setup");

  // Refused places answer with an error and empty data
  property p_slverr;
    @(posedge core_clk) disable iff (!rst_n)
      (setup && !map_ok) |=> apb_rsp.pslverr && (apb_rsp.prdata == '0);
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("refused access without error answer");

  // A source-select write lands at the access edge
  property p_src_wr;
    @(posedge core_clk) disable iff (!rst_n)
      (acc_wr && (apb_req.paddr == `DPGIO_OFF_A_SRC))
        |=> (st_ff.ctl_a == $past(apb_req.pwdata[`DPGIO_SRC_BIT]));
  endproperty
  a_src_wr: assert property (p_src_wr)
    else $error("source select write lost");

  // Edge status stays set until software clears it
  property p_sticky;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (($past(st_ff.raw) & $past(st_ff.itype) & ~$past(clr_raw)
                 & st_ff.inten & ~st_ff.raw) == '0);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("edge status dropped without a clear");

  // An enabled falling edge on a falling-edge line is caught next cycle
  property p_fall;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (($past(st_ff.itype) & ~$past(st_ff.ipol) & ~$past(st_ff.filt)
                 & $past(st_ff.filt_d) & st_ff.inten & ~st_ff.raw) == '0);
  endproperty
  a_fall: assert property (p_fall)
    else $error("falling edge not latched");

  // Second-port levels pass the synchroniser with no filter in the way
  property p_lvl_b;
    @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> (line_b_lvl == $past(st_ff.sb2));
  endproperty
  a_lvl_b: assert property (p_lvl_b)
    else $error("second port level not the synchronised pad");

endmodule

// ===== inc/dpgio_defs.svh
// Constants of the dual-port GPIO block: offsets, widths, reset values
// ---------------------------------------------------------------------
// How it works
// - There are two bidirectional ports, the first 18 lines wide and the second 17 lines wide.
// - With every line used as GPIO, pads 00 to 17 belong to the first port, 18 to 34 to the second.
// - Every line of both ports is offered as a wake-up source; only first-port lines raise interrupts.
// - Only first-port lines get a glitch filter; second-port lines are never filtered.
// - Each line is an input or an output, software writes its output value and reads line data.
// - The output-data registers at 0x00 and 0x0C drive their port's lines and reset to zero.
// - Each direction bit at 0x04 or 0x10 makes its line an input when 0, an output when 1; reset is input.
// - Bit 0 at 0x08 or 0x14 picks software registers (0) or hardware functions (1); reset is software.
// - A set bit of the interrupt enable at 0x30 makes its first-port line an interrupt source; reset off.
// - A set bit of the interrupt mask at 0x34 blocks that line's interrupt; reset is unmasked.
// - Register bits above a port's width, and bits 31 to 1 of the source registers, read as zero.
// - A per-line type bit picks level (0) or edge (1) sensitivity; reset is level.
// - A per-line polarity bit picks active-low or falling edge (0), active-high or rising edge (1).
// - Raw interrupt status and masked interrupt status of the first port are readable.
// - A set debounce bit filters glitches from that line before detection; a clear bit filters nothing.
// ---------------------------------------------------------------------
`ifndef DPGIO_DEFS_SVH
`define DPGIO_DEFS_SVH

// ---------------------------------------------------------------------
// Widths and counts
// ---------------------------------------------------------------------
`define DPGIO_A_W 18
`define DPGIO_B_W 17
`define DPGIO_DEB_LEN 4
`define DPGIO_ADDR_W 12
`define DPGIO_DATA_W 32
`define DPGIO_SRC_BIT 0
`define DPGIO_RST_ZERO '0

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define DPGIO_OFF_A_DR 12'h000
`define DPGIO_OFF_A_DDR 12'h004
`define DPGIO_OFF_A_SRC 12'h008
`define DPGIO_OFF_B_DR 12'h00C
`define DPGIO_OFF_B_DDR 12'h010
`define DPGIO_OFF_B_SRC 12'h014
`define DPGIO_OFF_IEN 12'h030
`define DPGIO_OFF_IMSK 12'h034
`define DPGIO_OFF_ITYP 12'h038
`define DPGIO_OFF_IPOL 12'h03C
`define DPGIO_OFF_ISTAT 12'h040
`define DPGIO_OFF_IRAW 12'h044
`define DPGIO_OFF_IDEB 12'h048
`define DPGIO_OFF_A_PIN 12'h050
`define DPGIO_OFF_B_PIN 12'h054

`endif

// ===== inc/dpgio_pkg.sv
// Types shared by the dual-port GPIO block and its surroundings
`include "dpgio_defs.svh"

package dpgio_pkg;

  // -------------------------------------------------------------------
  // APB request and answer
  // -------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`DPGIO_ADDR_W-1:0] paddr;
    logic [`DPGIO_DATA_W-1:0] pwdata;
  } dpgio_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [`DPGIO_DATA_W-1:0] prdata;
  } dpgio_apb_rsp_t;

  // -------------------------------------------------------------------
  // Line drive bundles: value and output enable per line
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [`DPGIO_A_W-1:0] dout;
    logic [`DPGIO_A_W-1:0] oe;
  } dpgio_drv_a_t;

  typedef struct packed {
    logic [`DPGIO_B_W-1:0] dout;
    logic [`DPGIO_B_W-1:0] oe;
  } dpgio_drv_b_t;

endpackage

// ===== verif/dpgio_pad_model.sv
// Pad model: resolves each line from the block's drive and the outside world
`timescale 1ns/1ps

module dpgio_pad_model (
  // Block drive
  input dpgio_pkg::dpgio_drv_a_t drv_a,
  input dpgio_pkg::dpgio_drv_b_t drv_b,
  // Outside sources, seen only where the block does not drive
  input logic [17:0] ext_a,
  input logic [16:0] ext_b,
  // Levels at the pads
  output logic [17:0] pad_a,
  output logic [16:0] pad_b
);
  import dpgio_pkg::*;

  // An enabled driver wins; no pulls modelled, so outside always drives
  assign pad_a = (drv_a.oe & drv_a.dout) | (~drv_a.oe & ext_a);
  assign pad_b = (drv_b.oe & drv_b.dout) | (~drv_b.oe & ext_b);
endmodule

// ===== verif/test_dual_port_gpio_with_irq.sv
// Self-checking bench for the dual-port GPIO block
`timescale 1ns/1ps
`include "dpgio_defs.svh"

module test_dual_port_gpio_with_irq;
  import dpgio_pkg::*;

  // ---------------------------------------------------------------
  // Bench state
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  dpgio_apb_req_t req = '0;
  dpgio_apb_rsp_t rsp;
  dpgio_drv_a_t drv_a;
  dpgio_drv_a_t hw_a = '0;
  dpgio_drv_b_t drv_b;
  dpgio_drv_b_t hw_b = '0;
  logic [17:0] ext_a = '0;
  logic [17:0] pad_a;
  logic [17:0] lvl_a;
  logic [16:0] ext_b = '0;
  logic [16:0] pad_b;
  logic [16:0] lvl_b;
  logic irq;
  logic [31:0] rdat;
  logic [31:0] bit1;
  logic [31:0] da;
  logic [31:0] oa;
  logic rerr;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int l;
  localparam logic [11:0] RW_REGS [11] = '{`DPGIO_OFF_A_DR, `DPGIO_OFF_A_DDR,
    `DPGIO_OFF_A_SRC, `DPGIO_OFF_B_DR, `DPGIO_OFF_B_DDR, `DPGIO_OFF_B_SRC,
    `DPGIO_OFF_IEN, `DPGIO_OFF_IMSK, `DPGIO_OFF_ITYP, `DPGIO_OFF_IPOL, `DPGIO_OFF_IDEB};

  // Short debounce keeps the filter cases quick
  dpgio_top #(.DEB_LEN(2)) uut (.core_clk(core_clk), .rst_n(rst_n), .apb_req(req),
    .apb_rsp(rsp), .pad_a_in(pad_a), .pad_a_drv(drv_a), .second_port_lines_in(pad_b),
    .second_port_lines_drv(drv_b), .hw_a(hw_a), .hw_b(hw_b), .line_a_lvl(lvl_a),
    .line_b_lvl(lvl_b), .irq(irq));

  dpgio_pad_model pads (.drv_a(drv_a), .drv_b(drv_b), .ext_a(ext_a), .ext_b(ext_b),
    .pad_a(pad_a), .pad_b(pad_b));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // Hang guard: whole run needs under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("unexpected %0t run timed out", $time);
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // Tasks and expectation functions
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge core_clk);
    req.penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, "read data");
    chk(rerr, 1'b0, "read error");
  endtask

  // Bounded wait for the interrupt level, then compare
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 30) begin
      @(posedge core_clk);
      n++;
    end
    chk(irq, e, "irq");
  endtask

  // Writable bits per register; the rest read zero
  function automatic logic [31:0] rw_mask(input logic [11:0] a);
    case (a)
      `DPGIO_OFF_A_SRC, `DPGIO_OFF_B_SRC: return 32'h0000_0001;
      `DPGIO_OFF_B_DR, `DPGIO_OFF_B_DDR: return 32'h0001_FFFF;
      default: return 32'h0003_FFFF;
    endcase
  endfunction

  function automatic logic [31:0] pad_exp(input logic [31:0] d, o, x);
    return (o & d) | (~o & x);
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rdat = $urandom(37);
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(drv_a, 36'h0, "reset drive a");
    chk({drv_b, irq}, 35'h0, "reset drive b");
    foreach (RW_REGS[i]) rd(RW_REGS[i], 32'h0);
    rd(`DPGIO_OFF_IRAW, 32'h0);
    // Random write and read back, reserved bits dropped
    for (int k = 0; k < 3; k++) begin
      foreach (RW_REGS[i]) begin
        da = $urandom;
        wr(RW_REGS[i], da);
        rd(RW_REGS[i], da & rw_mask(RW_REGS[i]));
      end
    end
    foreach (RW_REGS[i]) wr(RW_REGS[i], 32'h0);
    wr(`DPGIO_OFF_IRAW, 32'hFFFF_FFFF);
    rd(`DPGIO_OFF_IRAW, 32'h0);
    // Unmapped and unaligned places answer with an error
    apb(1'b0, 12'h020, 32'h0);
    chk({rerr, rdat}, 33'h1_0000_0000, "unmapped");
    apb(1'b0, 12'h006, 32'h0);
    chk({rerr, rdat}, 33'h1_0000_0000, "unaligned");
    // Software drive of both ports, pad levels read back
    for (int k = 0; k < 4; k++) begin
      da = $urandom;
      oa = $urandom;
      ext_a <= 18'($urandom);
      ext_b <= 17'($urandom);
      wr(`DPGIO_OFF_A_DR, da);
      wr(`DPGIO_OFF_A_DDR, oa);
      wr(`DPGIO_OFF_B_DR, ~da);
      wr(`DPGIO_OFF_B_DDR, ~oa);
      repeat (2) @(posedge core_clk);
      chk(drv_a, {da[17:0], oa[17:0]}, "port a drive");
      chk(drv_b, {~da[16:0], ~oa[16:0]}, "port b drive");
      repeat (4) @(posedge core_clk);
      chk(lvl_a, 18'(pad_exp(da, oa, ext_a)), "level a");
      chk(lvl_b, 17'(pad_exp(~da, ~oa, ext_b)), "level b");
      rd(`DPGIO_OFF_A_PIN, pad_exp(da, oa, ext_a) & 32'h3FFFF);
      rd(`DPGIO_OFF_B_PIN, pad_exp(~da, ~oa, ext_b) & 32'h1FFFF);
    end
    // Hardware mode hands both ports to the function signals
    hw_a <= 36'($urandom) ^ {36{da[3]}};
    hw_b <= 34'($urandom);
    wr(`DPGIO_OFF_A_SRC, 32'h1);
    wr(`DPGIO_OFF_B_SRC, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(drv_a, hw_a, "hw a");
    chk(drv_b, hw_b, "hw b");
    wr(`DPGIO_OFF_A_SRC, 32'h0);
    wr(`DPGIO_OFF_B_SRC, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(drv_a, {da[17:0], oa[17:0]}, "sw a again");
    wr(`DPGIO_OFF_A_DDR, 32'h0);
    // Every trigger type and polarity on its own line
    for (int m = 0; m < 4; m++) begin
      l = 3 + 4 * m;
      bit1 = 32'h1 << l;
      ext_a[l] <= ~m[0];
      repeat (8) @(posedge core_clk);
      wr(`DPGIO_OFF_ITYP, m[1] ? bit1 : 32'h0);
      wr(`DPGIO_OFF_IPOL, m[0] ? bit1 : 32'h0);
      wr(`DPGIO_OFF_IEN, bit1);
      wr(`DPGIO_OFF_IRAW, bit1);
      wait_irq(1'b0);
      ext_a[l] <= m[0];
      wait_irq(1'b1);
      rd(`DPGIO_OFF_IRAW, bit1);
      rd(`DPGIO_OFF_ISTAT, bit1);
      wr(`DPGIO_OFF_IMSK, bit1);
      wait_irq(1'b0);
      rd(`DPGIO_OFF_ISTAT, 32'h0);
      rd(`DPGIO_OFF_IRAW, bit1);
      wr(`DPGIO_OFF_IMSK, 32'h0);
      wait_irq(1'b1);
      ext_a[l] <= ~m[0];
      repeat (8) @(posedge core_clk);
      rd(`DPGIO_OFF_IRAW, m[1] ? bit1 : 32'h0);
      wr(`DPGIO_OFF_IRAW, bit1);
      rd(`DPGIO_OFF_IRAW, 32'h0);
      wait_irq(1'b0);
      wr(`DPGIO_OFF_IEN, 32'h0);
    end
    // One-cycle glitch: passed without the filter, dropped with it
    for (int d = 0; d < 2; d++) begin
      // Line starts low so the pulse is a true rising edge
      ext_a[10] <= 1'b0;
      wr(`DPGIO_OFF_IDEB, d ? 32'h400 : 32'h0);
      wr(`DPGIO_OFF_ITYP, 32'h400);
      wr(`DPGIO_OFF_IPOL, 32'h400);
      wr(`DPGIO_OFF_IEN, 32'h400);
      wr(`DPGIO_OFF_IRAW, 32'h400);
      @(posedge core_clk);
      ext_a[10] <= 1'b1;
      @(posedge core_clk);
      ext_a[10] <= 1'b0;
      repeat (12) @(posedge core_clk);
      rd(`DPGIO_OFF_IRAW, d ? 32'h0 : 32'h400);
      wr(`DPGIO_OFF_IRAW, 32'h400);
      ext_a[10] <= 1'b1;
      wait_irq(1'b1);
      ext_a[10] <= 1'b0;
      repeat (8) @(posedge core_clk);
      wr(`DPGIO_OFF_IRAW, 32'h400);
      wait_irq(1'b0);
    end
    tally_and_finish();
  end
endmodule
